/* File: verilog/qsfs_pkg.sv */
package qsfs_pkg;
   // Clock and timing
   localparam int CLK_MHZ = 50;
   localparam int CB_FILT_BASE_US = 25;
   localparam int CB_FILT_BASE_CYC = CB_FILT_BASE_US * CLK_MHZ;
   localparam int CROWBAR_US = 20;
   localparam int CROWBAR_CYC = CROWBAR_US * CLK_MHZ;
   localparam int NV_WRITE_US = 5000;
   localparam int NV_WRITE_CYC = NV_WRITE_US * CLK_MHZ;
   localparam int NMGR = 4;
   localparam int AW = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_GLOBAL = 8'h00;
   localparam logic [7:0] OFS_RST_SEL = 8'h04;
   localparam logic [7:0] OFS_ALERT_SEL = 8'h08;
   localparam logic [7:0] OFS_OC_CFG = 8'h0C;
   localparam logic [7:0] OFS_MODE = 8'h10;
   localparam logic [7:0] OFS_HOLD = 8'h14;
   localparam logic [7:0] OFS_THR0 = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h28;
   // Fault register indices; byte address is four times the index
   localparam logic [5:0] IDX_FAULT_BUS = 6'h1D;
   localparam logic [5:0] IDX_FAULT_CARD = 6'h1E;
   localparam logic [5:0] IDX_FAULT_TRK = 6'h1F;

   // Global register fields
   localparam int G_PUMP_POL = 0;
   localparam int G_PWR_POL = 1;
   localparam int G_SD_POL = 2;
   localparam int G_CBF_POL = 3;
   localparam int G_MR_WR_LVL = 4;
   localparam int G_FSD_TRK = 5;
   localparam int G_FSD_ALERT = 6;
   localparam int G_FSD_OC = 7;
   localparam int G_CROWBAR_EN = 8;
   // Reset select fields: warn, crit, trip groups of four
   localparam int RS_WARN = 0;
   localparam int RS_CRIT = 4;
   localparam int RS_OC = 8;
   // Alert select fields
   localparam int AS_UV = 0;
   localparam int AS_OV = 4;
   localparam int AS_WARN = 8;
   localparam int AS_CRIT = 12;
   localparam int AS_OC = 16;
   // Per-manager breaker nibble: limit, filter[2:1], fast enable
   localparam int OC_LIM50 = 0;
   localparam int OC_FILT = 1;
   localparam int OC_FAST = 3;
   // Mode fields
   localparam int M_SOFT = 0;
   localparam int M_TRACK = 4;
   localparam int M_TRK_ALERT = 8;
   localparam int HOLD_W = 24;

   // Reset values
   localparam logic [31:0] GLOBAL_RST = 32'h0000_001F;
   localparam logic [31:0] RST_SEL_RST = 32'h0000_00F0;
   localparam logic [31:0] ALERT_SEL_RST = 32'h0000_0000;
   localparam logic [31:0] OC_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] MODE_RST = 32'h0000_000F;
   localparam logic [31:0] HOLD_RST = 32'h0000_C350;
   localparam logic [31:0] THR_RST = 32'h0000_0000;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // Synchronised comparator and gate status, bit i is manager i+1
   typedef struct packed {
      logic [3:0] bus_uv;
      logic [3:0] bus_ov;
      logic [3:0] card_warn;
      logic [3:0] card_crit;
      logic [3:0] cb_over;
      logic [3:0] fast_over;
      logic [3:0] track_dev;
      logic [3:0] gate_full;
   } qsfs_comp_t;

   // Threshold codes sent to one manager's comparators
   typedef struct packed {
      logic [4:0] crit;
      logic [7:0] warn;
      logic [4:0] ov;
      logic [7:0] low;
   } qsfs_thr_t;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_SOFT = 2'b01,
      SEQ_TRACK = 2'b11,
      SEQ_ON = 2'b10
   } qsfs_seq_t;
endpackage : qsfs_pkg

/* File: verilog/qsfs_top.sv */
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
// Overview of operation
// [R1] Bus-side level below low threshold flags bus_undervolt; code sets 20 mV steps.
// [R2] Bus-side above high threshold flags bus_overvolt; code scales low threshold.
// [R3] bus_overvolt is its own status, separate from the low fault.
// [R4] Card-side below primary threshold flags card_warn_low; 20 mV step code.
// [R5] Card-side below secondary threshold flags card_critical_low; 5-bit percent code.
// [R6] low_fault_mask high ignores every undervoltage status.
// [R7] Sense drop above limit longer than selected filter raises overcurrent_trip.
// [R8] Enabled fast comparator raises overcurrent_trip at once; can be off.
// [R9] overcurrent_trip routes to reset, alert, or shutdown with crowbar pulse.
// [R10] All resets assert at power-up, held reset_hold_time after conditions clear.
// [R11] Each reset selects warn, critical or trip sources, held after clearing.
// [R12] manual_reset_n low forces all resets; release reset_hold_time after.
// [R13] alert_n from selected sources latches; falling alert_clear_n clears it.
// [R14] Pump runs only while enable input is at its programmed active level.
// [R15] Power-on needs request, both cards present, no shutdown; polarities set.
// [R16] Tracking gates stay off until all softstart gates are fully on.
// [R17] tracking_alert_n asserts on tracked level mismatch during tracking interval.
// [R18] shutdown_request or internal_shutdown turns all gates off at once.
// [R19] all_good_n asserted while no enabled unlatched condition is active.
// [R20] breaker_fault_out follows overcurrent_trip with selectable polarity.
// [R21] Each new alert overwrites three fault registers with its causes.
// [R22] Fault registers read any time except during a nonvolatile write.
// [R23] Fault registers cleared by write with no fault, at permitted reset level.
// [R24] No fault recording while power_request is deasserted.
// [R25] Fault layout: low/high, warn/critical, track/trip; manager one MSB.
// [R26] Comparator inputs synchronised; hold and filter times are cycle counters.
module qsfs_top
   import qsfs_pkg::*;
#(
   parameter int CB_FILT_CYC = CB_FILT_BASE_CYC,
   parameter int NV_WR_CYC = NV_WRITE_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // AXI4-Lite write
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Comparator status
   input wire qsfs_comp_t comp_in,
   // Control pins
   input wire logic low_fault_mask,
   input wire logic manual_reset_n,
   input wire logic alert_clear_n,
   input wire logic pump_enable_in,
   input wire logic power_request,
   input wire logic shutdown_request,
   input wire logic card_present_a_n,
   input wire logic card_present_b_n,
   // Comparator settings
   output qsfs_thr_t [3:0] thr_code,
   output logic [3:0] cb_limit_50,
   // Status and drive outputs
   output logic [3:0] reset_n_out,
   output logic alert_n,
   output logic tracking_alert_n,
   output logic all_good_n,
   output logic breaker_fault_out,
   output logic internal_shutdown,
   output logic crowbar,
   output logic pump_run,
   output logic [3:0] gate_drive
);
   logic [1:0] rst_q;
   logic rst_n;
   qsfs_comp_t comp_s1_q, comp_s2_q;
   logic [31:0] glob_q, rsel_q, asel_q, occ_q, mode_q, hold_q;
   logic [31:0] thr_q [NMGR];
   logic [7:0] f_bus_q, f_card_q, f_trk_q;
   logic [3:0] uv_m, warn_m, crit_m, oc, rst_cond;
   logic [3:0] c_uv, c_ov, c_warn, c_crit, c_oc, c_trk;
   logic alert_raw, alert_raw_q, clr_prev_q, trk_raw, pwr_act, sd_act;
   logic seq_ok, kill, fsd_q, fsd_prev_q, rec, nv_busy;
   logic [$clog2(NV_WR_CYC+1)-1:0] nv_cnt_q;
   logic [$clog2(CROWBAR_CYC+1)-1:0] cb_cnt_q;
   qsfs_seq_t seq_q;
   logic [AW-1:0] aw_addr_q;
   logic [31:0] w_data_q, wmask;
   logic [3:0] w_strb_q;
   logic aw_have_q, w_have_q, do_wr, wr_fault_ok;
   logic [31:0] rd_data;
   logic [1:0] rd_resp, wr_resp;

   function automatic logic is_fault(input logic [AW-1:0] a);
      is_fault = (a[7:2] == IDX_FAULT_BUS) || (a[7:2] == IDX_FAULT_CARD) ||
         (a[7:2] == IDX_FAULT_TRK);
   endfunction : is_fault

   // Manager one goes to the most significant bit
   function automatic logic [3:0] rev4(input logic [3:0] v);
      rev4 = {v[0], v[1], v[2], v[3]};
   endfunction : rev4

   // Reset release through two flip-flops
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_q <= 2'b00;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // Comparator synchroniser
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         comp_s1_q <= '0;
         comp_s2_q <= '0;
      end else begin
         comp_s1_q <= comp_in; // [R26]
         comp_s2_q <= comp_s1_q;
      end
   end

   // Threshold codes to comparators
   for (genvar i = 0; i < NMGR; i++) begin : g_thr
      assign thr_code[i] = qsfs_thr_t'(thr_q[i][25:0]); // [R1] [R2] [R4] [R5]
      assign cb_limit_50[i] = occ_q[4*i+OC_LIM50]; // [R7]
   end

   // Undervoltage masking
   assign uv_m = comp_s2_q.bus_uv & ~{4{low_fault_mask}}; // [R6] [R1]
   assign warn_m = comp_s2_q.card_warn & ~{4{low_fault_mask}}; // [R6] [R4]
   assign crit_m = comp_s2_q.card_crit & ~{4{low_fault_mask}}; // [R6] [R5]

   // Breaker filter and fast trip
   for (genvar i = 0; i < NMGR; i++) begin : g_cb
      logic [15:0] filt_cnt_q;
      logic [15:0] limit;
      assign limit = 16'(CB_FILT_CYC) << occ_q[4*i+OC_FILT +: 2];
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            filt_cnt_q <= '0;
         end else if (!comp_s2_q.cb_over[i]) begin
            filt_cnt_q <= '0;
         end else if (filt_cnt_q != limit) begin
            filt_cnt_q <= filt_cnt_q + 16'd1; // [R7] [R26]
         end
      end
      assign oc[i] = (filt_cnt_q == limit) || // [R7]
         (occ_q[4*i+OC_FAST] && comp_s2_q.fast_over[i]); // [R8]
   end

   // Stretched resets
   for (genvar i = 0; i < NMGR; i++) begin : g_rst
      logic [HOLD_W-1:0] hold_cnt_q;
      assign rst_cond[i] = (warn_m[i] && rsel_q[RS_WARN+i]) ||
         (crit_m[i] && rsel_q[RS_CRIT+i]) ||
         (oc[i] && rsel_q[RS_OC+i]); // [R11] [R9]
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            hold_cnt_q <= HOLD_RST[HOLD_W-1:0]; // [R10]
            reset_n_out[i] <= 1'b0;
         end else begin
            if (rst_cond[i] || !manual_reset_n) begin
               hold_cnt_q <= hold_q[HOLD_W-1:0]; // [R12] [R26]
            end else if (hold_cnt_q != '0) begin
               hold_cnt_q <= hold_cnt_q - 1'b1;
            end
            reset_n_out[i] <= !(rst_cond[i] || !manual_reset_n ||
               hold_cnt_q != '0); // [R10] [R11] [R12]
         end
      end
   end

   // Alert causes
   assign c_uv = uv_m & asel_q[AS_UV +: 4]; // [R13]
   assign c_ov = comp_s2_q.bus_ov & asel_q[AS_OV +: 4]; // [R2] [R3]
   assign c_warn = warn_m & asel_q[AS_WARN +: 4];
   assign c_crit = crit_m & asel_q[AS_CRIT +: 4];
   assign c_oc = oc & asel_q[AS_OC +: 4]; // [R9]
   assign alert_raw = |{c_uv, c_ov, c_warn, c_crit, c_oc};

   // Alert latch, set wins over clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         alert_n <= 1'b1;
         alert_raw_q <= 1'b0;
         clr_prev_q <= 1'b1;
      end else begin
         alert_raw_q <= alert_raw;
         clr_prev_q <= alert_clear_n;
         if (alert_raw) begin
            alert_n <= 1'b0; // [R13]
         end else if (clr_prev_q && !alert_clear_n) begin
            alert_n <= 1'b1;
         end
      end
   end

   // Sequencing
   assign pwr_act = power_request == glob_q[G_PWR_POL];
   assign sd_act = shutdown_request == glob_q[G_SD_POL];
   assign seq_ok = pwr_act && !card_present_a_n && !card_present_b_n &&
      !sd_act; // [R15]
   assign kill = sd_act || fsd_q; // [R18]
   assign c_trk = comp_s2_q.track_dev & mode_q[M_TRACK +: 4] &
      {4{seq_q == SEQ_TRACK}};
   assign trk_raw = mode_q[M_TRK_ALERT] && (|c_trk); // [R17]

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_q <= SEQ_IDLE;
      end else if (kill || !seq_ok) begin
         seq_q <= SEQ_IDLE; // [R18]
      end else begin
         case (seq_q)
            SEQ_IDLE: seq_q <= SEQ_SOFT; // [R15]
            SEQ_SOFT: begin
               if (&(comp_s2_q.gate_full | ~mode_q[M_SOFT +: 4])) begin
                  seq_q <= SEQ_TRACK; // [R16]
               end
            end
            SEQ_TRACK: begin
               if (&(comp_s2_q.gate_full |
                  ~(mode_q[M_SOFT +: 4] | mode_q[M_TRACK +: 4]))) begin
                  seq_q <= SEQ_ON;
               end
            end
            SEQ_ON: seq_q <= SEQ_ON;
            default: seq_q <= SEQ_IDLE;
         endcase
      end
   end

   // Gate drive, pump and status pins
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         gate_drive <= '0;
         pump_run <= 1'b0;
         tracking_alert_n <= 1'b1;
         all_good_n <= 1'b1;
         breaker_fault_out <= 1'b0;
      end else begin
         if (kill || seq_q == SEQ_IDLE) begin
            gate_drive <= '0; // [R18]
         end else if (seq_q == SEQ_SOFT) begin
            gate_drive <= mode_q[M_SOFT +: 4]; // [R16]
         end else begin
            gate_drive <= mode_q[M_SOFT +: 4] | mode_q[M_TRACK +: 4];
         end
         pump_run <= pump_enable_in == glob_q[G_PUMP_POL]; // [R14]
         tracking_alert_n <= !trk_raw; // [R17]
         all_good_n <= (|rst_cond) || alert_raw || trk_raw; // [R19]
         breaker_fault_out <= (|oc) ^ !glob_q[G_CBF_POL]; // [R20]
      end
   end

   // Internal shutdown and crowbar pulse
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fsd_q <= 1'b0;
         fsd_prev_q <= 1'b0;
         cb_cnt_q <= '0;
      end else begin
         if ((glob_q[G_FSD_TRK] && trk_raw) ||
            (glob_q[G_FSD_ALERT] && !alert_n) ||
            (glob_q[G_FSD_OC] && (|oc))) begin
            fsd_q <= 1'b1; // [R18] [R9]
         end else if (!pwr_act) begin
            fsd_q <= 1'b0;
         end
         fsd_prev_q <= fsd_q;
         if (fsd_q && !fsd_prev_q && glob_q[G_CROWBAR_EN]) begin
            cb_cnt_q <= ($bits(cb_cnt_q))'(CROWBAR_CYC); // [R9]
         end else if (cb_cnt_q != '0) begin
            cb_cnt_q <= cb_cnt_q - 1'b1;
         end
      end
   end
   assign internal_shutdown = fsd_q;
   assign crowbar = cb_cnt_q != '0;

   // Fault recording and nonvolatile write timer
   assign rec = alert_raw && !alert_raw_q && pwr_act; // [R21] [R24]
   assign nv_busy = nv_cnt_q != '0;
   assign wr_fault_ok = is_fault(aw_addr_q) && w_strb_q[0] &&
      manual_reset_n == glob_q[G_MR_WR_LVL] &&
      !alert_raw && !(|rst_cond) && !trk_raw; // [R23]

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         f_bus_q <= '0;
         f_card_q <= '0;
         f_trk_q <= '0;
         nv_cnt_q <= '0;
      end else begin
         if (rec) begin
            f_bus_q <= {rev4(c_uv), rev4(c_ov)}; // [R21] [R25]
            f_card_q <= {rev4(c_warn), rev4(c_crit)};
            f_trk_q <= {rev4(c_trk), rev4(c_oc)};
         end else if (do_wr && wr_fault_ok) begin
            case (aw_addr_q[7:2])
               IDX_FAULT_BUS: f_bus_q <= w_data_q[7:0]; // [R23]
               IDX_FAULT_CARD: f_card_q <= w_data_q[7:0];
               default: f_trk_q <= w_data_q[7:0];
            endcase
         end
         if (rec || (do_wr && wr_fault_ok)) begin
            nv_cnt_q <= ($bits(nv_cnt_q))'(NV_WR_CYC);
         end else if (nv_busy) begin
            nv_cnt_q <= nv_cnt_q - 1'b1;
         end
      end
   end

   // AXI write channel
   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready = !w_have_q && !s_axi_bvalid;
   assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid &&
      !(nv_busy && is_fault(aw_addr_q)); // [R22]
   for (genvar b = 0; b < 4; b++) begin : g_mask
      assign wmask[8*b +: 8] = {8{w_strb_q[b]}};
   end

   always_comb begin
      wr_resp = RESP_OKAY;
      if (is_fault(aw_addr_q)) begin
         wr_resp = wr_fault_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (aw_addr_q == OFS_STATUS) begin
         wr_resp = RESP_SLVERR;
      end else if (aw_addr_q[1:0] != 2'b00 || aw_addr_q > OFS_STATUS) begin
         wr_resp = RESP_DECERR;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_resp;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         glob_q <= GLOBAL_RST;
         rsel_q <= RST_SEL_RST;
         asel_q <= ALERT_SEL_RST;
         occ_q <= OC_CFG_RST;
         mode_q <= MODE_RST;
         hold_q <= HOLD_RST;
         for (int i = 0; i < NMGR; i++) begin
            thr_q[i] <= THR_RST;
         end
      end else if (do_wr && wr_resp == RESP_OKAY) begin
         case (aw_addr_q)
            OFS_GLOBAL: glob_q <= (glob_q & ~wmask) | (w_data_q & wmask);
            OFS_RST_SEL: rsel_q <= (rsel_q & ~wmask) | (w_data_q & wmask);
            OFS_ALERT_SEL: asel_q <= (asel_q & ~wmask) | (w_data_q & wmask);
            OFS_OC_CFG: occ_q <= (occ_q & ~wmask) | (w_data_q & wmask);
            OFS_MODE: mode_q <= (mode_q & ~wmask) | (w_data_q & wmask);
            OFS_HOLD: hold_q <= (hold_q & ~wmask) | (w_data_q & wmask);
            default: begin
               for (int i = 0; i < NMGR; i++) begin
                  if (aw_addr_q == OFS_THR0 + 8'(4 * i)) begin
                     thr_q[i] <= (thr_q[i] & ~wmask) | (w_data_q & wmask);
                  end
               end
            end
         endcase
      end
   end

   // AXI read channel
   assign s_axi_arready = !s_axi_rvalid &&
      !(nv_busy && is_fault(s_axi_araddr)); // [R22]

   always_comb begin
      rd_data = '0;
      rd_resp = RESP_OKAY;
      case (s_axi_araddr)
         OFS_GLOBAL: rd_data = glob_q;
         OFS_RST_SEL: rd_data = rsel_q;
         OFS_ALERT_SEL: rd_data = asel_q;
         OFS_OC_CFG: rd_data = occ_q;
         OFS_MODE: rd_data = mode_q;
         OFS_HOLD: rd_data = hold_q;
         OFS_STATUS: rd_data = {12'h000, gate_drive, pump_run, seq_q,
            nv_busy, fsd_q, all_good_n, tracking_alert_n, alert_n,
            reset_n_out, oc};
         {IDX_FAULT_BUS, 2'b00}: rd_data = {24'h00_0000, f_bus_q};
         {IDX_FAULT_CARD, 2'b00}: rd_data = {24'h00_0000, f_card_q};
         {IDX_FAULT_TRK, 2'b00}: rd_data = {24'h00_0000, f_trk_q};
         default: begin
            rd_resp = RESP_DECERR;
            for (int i = 0; i < NMGR; i++) begin
               if (s_axi_araddr == OFS_THR0 + 8'(4 * i)) begin
                  rd_data = thr_q[i];
                  rd_resp = RESP_OKAY;
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_resp;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : qsfs_top

/* File: bench/qsfs_props.sv */
`timescale 1ns/1ps
module qsfs_props
   import qsfs_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Inputs watched
   input wire qsfs_comp_t comp_in,
   input wire logic manual_reset_n,
   input wire logic alert_clear_n,
   input wire logic pump_enable_in,
   input wire logic power_request,
   input wire logic shutdown_request,
   input wire logic card_present_a_n,
   // Outputs watched
   input wire logic [3:0] reset_n_out,
   input wire logic alert_n,
   input wire logic breaker_fault_out,
   input wire logic pump_run,
   input wire logic [3:0] gate_drive
);
   int mr_hi_q;
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Cycles since manual reset was last low
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mr_hi_q <= 0;
      end else if (!manual_reset_n) begin
         mr_hi_q <= 0;
      end else if (mr_hi_q < 1000) begin
         mr_hi_q <= mr_hi_q + 1;
      end
   end
   a_rst_hold: assert property ($rose(reset_n_out[0]) |-> mr_hi_q >= 16)
      else $error("reset released too early");
   a_mr_low: assert property (!manual_reset_n [*4] |-> reset_n_out == 4'h0)
      else $error("manual reset not forcing resets");
   a_alert_latch: assert property ((!alert_n && alert_clear_n) [*6] |=> !alert_n)
      else $error("alert released without clear edge");
   a_sd_off: assert property (shutdown_request [*4] |-> gate_drive == 4'h0)
      else $error("gates on during shutdown");
   a_absent_off: assert property ((gate_drive == 4'h0 && card_present_a_n) [*6]
      |=> gate_drive == 4'h0)
      else $error("gates started with card absent");
   a_no_request: assert property (!power_request [*6] |-> gate_drive == 4'h0)
      else $error("gates on without power request");
   a_pump_off: assert property (!pump_enable_in [*4] |-> !pump_run)
      else $error("pump running while disabled");
   a_trip_idle: assert property ((comp_in.cb_over == 4'h0 &&
      comp_in.fast_over == 4'h0) [*8] |=> !breaker_fault_out)
      else $error("breaker fault without cause");
endmodule : qsfs_props
bind qsfs_top qsfs_props u_qsfs_props (.sys_clk, .rst_b, .comp_in,
   .manual_reset_n, .alert_clear_n, .pump_enable_in, .power_request,
   .shutdown_request, .card_present_a_n, .reset_n_out, .alert_n,
   .breaker_fault_out, .pump_run, .gate_drive);

/* File: bench/qsfs_fets.sv */
`timescale 1ns/1ps
module qsfs_fets (
   // Clock
   input wire logic sys_clk,
   // Gate drive in, fully-on status out
   input wire logic [3:0] gate_drive,
   output logic [3:0] gate_full
);
   logic [3:0] ramp1_q = 4'h0;
   logic [3:0] ramp2_q = 4'h0;
   initial gate_full = 4'h0;
   // Gate reaches full drive a few cycles after enable, drops at once
   always_ff @(posedge sys_clk) begin
      ramp1_q <= gate_drive;
      ramp2_q <= ramp1_q & gate_drive;
      gate_full <= ramp2_q & gate_drive;
   end
endmodule : qsfs_fets

/* File: bench/qsfs_top_tb.sv */
`timescale 1ns/1ps
module qsfs_top_tb;
   import qsfs_pkg::*;
   logic sys_clk = 0, rst_b = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF, gfull, cb_limit_50, reset_n_out, gate_drive;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, alert_n, tracking_alert_n, all_good_n, crowbar;
   logic breaker_fault_out, internal_shutdown, pump_run;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   qsfs_comp_t comp_in, cmp = '0;
   qsfs_thr_t [3:0] thr_code;
   logic low_fault_mask = 0, manual_reset_n = 1, alert_clear_n = 1;
   logic pump_enable_in = 1, power_request = 0, shutdown_request = 0;
   logic card_present_a_n = 1, card_present_b_n = 1;
   int miscompares = 0, n_compared = 0, n;
   always #10 sys_clk = ~sys_clk;
   always_comb begin
      comp_in = cmp;
      comp_in.gate_full = gfull;
   end
   qsfs_top #(.CB_FILT_CYC(4), .NV_WR_CYC(8)) u_qsfs_top (.sys_clk, .rst_b,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .comp_in, .low_fault_mask, .manual_reset_n,
      .alert_clear_n, .pump_enable_in, .power_request, .shutdown_request,
      .card_present_a_n, .card_present_b_n, .thr_code, .cb_limit_50,
      .reset_n_out, .alert_n, .tracking_alert_n, .all_good_n,
      .breaker_fault_out, .internal_shutdown, .crowbar, .pump_run,
      .gate_drive);
   qsfs_fets u_qsfs_fets (.sys_clk, .gate_drive, .gate_full(gfull));
   task automatic end_sim;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] e, s);
      n_compared++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (int i = 0; i < 300; i++) begin
         @(negedge sys_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge sys_clk);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
         if (tb) begin
            s_axi_bready <= 0;
            return;
         end
      end
      miscompares++;
      end_sim();
   endtask : wr
   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (int i = 0; i < 300; i++) begin
         @(negedge sys_clk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge sys_clk);
         if (ta) s_axi_arvalid <= 0;
         if (tr) begin
            s_axi_rready <= 0;
            return;
         end
      end
      miscompares++;
      end_sim();
   endtask : rd
   initial begin
      tick(8);
      rst_b <= 1;
      tick(3);
      rd(OFS_GLOBAL); chk("global", GLOBAL_RST, d);
      rd(OFS_RST_SEL); chk("rst_sel", RST_SEL_RST, d);
      rd(OFS_HOLD); chk("hold", HOLD_RST, d);
      rd(8'h2C); chk("unmapped", 32'(RESP_DECERR), 32'(r));
      wr(OFS_HOLD, 32'h0000_0010);
      n = 0;
      while (reset_n_out !== 4'hF && n < 51000) begin tick(1); n++; end
      chk("power-up", 4'hF, reset_n_out);
      manual_reset_n <= 0;
      tick(5); chk("mr low", 4'h0, reset_n_out);
      manual_reset_n <= 1;
      n = 0;
      while (reset_n_out !== 4'hF && n < 40) begin tick(1); n++; end
      chk("mr hold", 1, 32'(n >= 16 && n <= 21));
      pump_enable_in <= 0;
      tick(5); chk("pump off", 0, pump_run);
      pump_enable_in <= 1;
      tick(5); chk("pump on", 1, pump_run);
      power_request <= 1;
      card_present_a_n <= 0;
      tick(8); chk("one card", 4'h0, gate_drive);
      card_present_b_n <= 0;
      n = 0;
      while (gate_drive !== 4'hF && n < 40) begin tick(1); n++; end
      chk("gates", 4'hF, gate_drive);
      shutdown_request <= 1;
      tick(5); chk("shutdown", 4'h0, gate_drive);
      wr(OFS_ALERT_SEL, 32'h0000_0001);
      low_fault_mask <= 1;
      cmp.bus_uv <= 4'h1;
      tick(8); chk("masked", 1, alert_n);
      low_fault_mask <= 0;
      tick(6); chk("alert", 0, alert_n);
      cmp.bus_uv <= 4'h0;
      tick(8); chk("latched", 0, alert_n);
      alert_clear_n <= 0;
      tick(6); chk("cleared", 1, alert_n);
      alert_clear_n <= 1;
      rd(8'h74); chk("fault bus", 32'h0000_0080, d);
      wr(8'h74, 32'h0000_0000); chk("clr resp", 32'(RESP_OKAY), 32'(r));
      rd(8'h74); chk("fault clr", 32'h0000_0000, d);
      wr(OFS_OC_CFG, 32'h0000_0008);
      cmp.fast_over <= 4'h1;
      tick(5); chk("fast trip", 1, breaker_fault_out);
      wr(OFS_OC_CFG, 32'h0000_0000);
      cmp.cb_over <= 4'h1;
      tick(3); chk("filter", 0, breaker_fault_out);
      tick(6); chk("slow trip", 1, breaker_fault_out);
      cmp <= '0;
      tick(10); chk("good", 0, all_good_n);
      end_sim();
   end
endmodule : qsfs_top_tb
